//--- hw/uart_rx_pkg.sv
// Constants shared by the serial receiver with wakeup
package uart_rx_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] CTRL_ONE_OFS = 3'h0;
  localparam logic [2:0] CTRL_TWO_OFS = 3'h1;
  localparam logic [2:0] STATUS_ONE_OFS = 3'h2;
  localparam logic [2:0] CTRL_THREE_OFS = 3'h3;
  localparam logic [2:0] DATA_PORT_OFS = 3'h4;
  localparam logic [2:0] BAUD_DIV_OFS = 3'h5;
  // control_reg_one fields
  localparam int C1_NINE_BIT = 0;
  localparam int C1_EXIT_METHOD = 1;
  localparam int C1_QUIET_START = 2;
  localparam int C1_INVERT = 3;
  localparam int C1_IDLE_SLEEP = 4;
  // control_reg_two fields
  localparam int C2_ENABLE = 0;
  localparam int C2_SLEEP = 1;
  // status_reg_one fields
  localparam int S1_PARITY = 0;
  localparam int S1_FRAMING = 1;
  localparam int S1_NOISE = 2;
  localparam int S1_OVERRUN = 3;
  localparam int S1_QUIET = 4;
  localparam int S1_FULL = 5;
  // control_reg_three fields
  localparam int C3_NINTH = 0;
  // Reset values
  localparam logic [7:0] CTRL_ONE_RST = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST = 8'h00;
  localparam logic [7:0] BAUD_DIV_RST = 8'h1a;
  // Sample phases, RT1 is code 0
  localparam logic [3:0] PH_RT3 = 4'h2;
  localparam logic [3:0] PH_RT5 = 4'h4;
  localparam logic [3:0] PH_RT7 = 4'h6;
  localparam logic [3:0] PH_RT8 = 4'h7;
  localparam logic [3:0] PH_RT9 = 4'h8;
  localparam logic [3:0] PH_RT10 = 4'h9;
  localparam logic [3:0] PH_RT16 = 4'hf;
  localparam int SAMPLES_PER_BIT = 16;
  localparam int IDLE_BITS_8 = 10;
  localparam int IDLE_BITS_9 = 11;
  localparam logic [7:0] IDLE_TICKS_8 = 8'(SAMPLES_PER_BIT * IDLE_BITS_8);
  localparam logic [7:0] IDLE_TICKS_9 = 8'(SAMPLES_PER_BIT * IDLE_BITS_9);
  typedef enum logic [1:0] {
    S_SEARCH = 2'b00,
    S_START = 2'b01,
    S_BITS = 2'b10
  } rx_state_type;
endpackage

//--- hw/uart_receiver_wakeup.sv
// Serial receiver with majority sampling, status flags and sleep wakeup
// Behaviour
// - Frame is start 0, 8/9 data LSB-first, stop 1
// - Invert input option; receive only when enabled
// - Stop received, buffer empty: store, set full
// - Full already: set overrun, drop new character
// - Sample at 16x; edge is 0 after three 1s
// - Start valid if two of RT3/5/7 zero
// - Each bit is majority of RT8/9/10
// - Start bit counts 0 once check passed
// - Any disagreeing sample sets noise on transfer
// - Every 0 after three 1s resynchronises sample phase
// - Framing error, not break: preload three ones
// - Framing flag set blocks transfer, shifting continues
// - Sleep suppresses flags except quiet if allowed and those of an exit method 1 wake character
// - Exit method 0: idle character time wakes
// - Quiet flag on wake idle only if allowed
// - Quiet count start after start or stop
// - Exit method 1: MSB one wakes, received
// - Full clears on status read then data read
// - Error flags set with full, never on overrun
// - Ninth bit goes to ninth_rx_bit
module uart_receiver_wakeup (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Serial line
  input wire logic serial_input,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  logic [7:0] ctrl_one_reg;
  logic [7:0] baud_reg;
  logic receiver_enable_reg;
  logic rx_sleep_reg;
  logic [1:0] rx_sync_reg;
  logic [7:0] div_cnt_reg;
  logic tick_reg;
  logic [2:0] hist_reg;
  uart_rx_pkg::rx_state_type state_reg;
  logic [3:0] phase_reg;
  logic [3:0] bit_idx_reg;
  logic [1:0] zero_cnt_reg;
  logic [1:0] ones_cnt_reg;
  logic frame_noise_reg;
  logic [8:0] shift_reg;
  logic done_reg;
  logic stop_bit_reg;
  logic [7:0] idle_cnt_reg;
  logic idle_hit_reg;
  logic [7:0] data_reg;
  logic ninth_rx_bit_reg;
  logic rx_full_flag_reg;
  logic overrun_flag_reg;
  logic noise_flag_reg;
  logic framing_error_flag_reg;
  logic quiet_line_flag_reg;
  logic quiet_armed_reg;
  logic status_seen_reg;

  logic nine_bit;
  logic rx_level;
  logic edge_det;
  logic [1:0] zeros_now;
  logic [1:0] ones_now;
  logic [3:0] stop_idx;
  logic is_break;
  logic [7:0] idle_thr;
  logic msb;
  logic wake_addr;
  logic clear_now;
  logic [7:0] status_byte;

  assign nine_bit = ctrl_one_reg[uart_rx_pkg::C1_NINE_BIT];
  assign rx_level = rx_sync_reg[1] ^ ctrl_one_reg[uart_rx_pkg::C1_INVERT];
  // edge is a 0 after three 1s
  assign edge_det = tick_reg && hist_reg == 3'b111 && !rx_level;
  assign zeros_now = zero_cnt_reg + {1'b0, !rx_level};
  assign ones_now = ones_cnt_reg + {1'b0, rx_level};
  // stop bit index follows frame length
  assign stop_idx = nine_bit ? 4'h9 : 4'h8;
  assign is_break = (shift_reg & (nine_bit ? 9'h1ff : 9'h0ff)) == 9'h000;
  assign idle_thr = nine_bit ? uart_rx_pkg::IDLE_TICKS_9
                             : uart_rx_pkg::IDLE_TICKS_8;
  assign msb = nine_bit ? shift_reg[8] : shift_reg[7];
  assign wake_addr = done_reg && rx_sleep_reg && msb
                     && ctrl_one_reg[uart_rx_pkg::C1_EXIT_METHOD];
  // second step of the clear sequence
  assign clear_now = reg_rd && reg_addr == uart_rx_pkg::DATA_PORT_OFS
                     && status_seen_reg;

  // Pin crossing into the core clock
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_sync_reg <= 2'b11;
    end else begin
      rx_sync_reg <= {rx_sync_reg[0], serial_input};
    end
  end

  // Software controls
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_one_reg <= uart_rx_pkg::CTRL_ONE_RST;
      baud_reg <= uart_rx_pkg::BAUD_DIV_RST;
      receiver_enable_reg <= 1'b0;
      rx_sleep_reg <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == uart_rx_pkg::CTRL_ONE_OFS) begin
        ctrl_one_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == uart_rx_pkg::BAUD_DIV_OFS) begin
        baud_reg <= reg_wdata;
      end
      if (reg_wr && reg_addr == uart_rx_pkg::CTRL_TWO_OFS) begin
        receiver_enable_reg <= reg_wdata[uart_rx_pkg::C2_ENABLE];
        rx_sleep_reg <= reg_wdata[uart_rx_pkg::C2_SLEEP];
      end
      if (idle_hit_reg && !ctrl_one_reg[uart_rx_pkg::C1_EXIT_METHOD]) begin
        rx_sleep_reg <= 1'b0;
      end
      if (wake_addr) begin
        rx_sleep_reg <= 1'b0;
      end
    end
  end

  // 16x sample enable; divisor is 8 bits, so slow rates need a slower clock
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else if (div_cnt_reg == 8'h00) begin
      div_cnt_reg <= baud_reg;
      tick_reg <= receiver_enable_reg;
    end else begin
      div_cnt_reg <= div_cnt_reg - 8'h01;
      tick_reg <= 1'b0;
    end
  end

  // Frame sequencer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hist_reg <= 3'b000;
      state_reg <= uart_rx_pkg::S_SEARCH;
      phase_reg <= 4'h0;
      bit_idx_reg <= 4'h0;
      zero_cnt_reg <= 2'b00;
      ones_cnt_reg <= 2'b00;
      frame_noise_reg <= 1'b0;
      shift_reg <= 9'h000;
      done_reg <= 1'b0;
      stop_bit_reg <= 1'b1;
    end else if (!receiver_enable_reg) begin
      hist_reg <= 3'b000;
      state_reg <= uart_rx_pkg::S_SEARCH;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (tick_reg) begin
        hist_reg <= {hist_reg[1:0], rx_level};
        phase_reg <= edge_det ? 4'h0 : phase_reg + 4'h1;
        unique case (state_reg)
          uart_rx_pkg::S_SEARCH: begin
            if (edge_det) begin
              state_reg <= uart_rx_pkg::S_START;
              zero_cnt_reg <= 2'b00;
              ones_cnt_reg <= 2'b00;
              frame_noise_reg <= 1'b0;
            end
          end
          uart_rx_pkg::S_START: begin
            // start check at RT3, RT5, RT7
            if (phase_reg == uart_rx_pkg::PH_RT3 ||
                phase_reg == uart_rx_pkg::PH_RT5) begin
              zero_cnt_reg <= zeros_now;
            end
            if (phase_reg == uart_rx_pkg::PH_RT7) begin
              frame_noise_reg <= zeros_now != 2'b11;
              if (zeros_now < 2'b10) begin
                state_reg <= uart_rx_pkg::S_SEARCH;
              end
            end
            if (phase_reg == uart_rx_pkg::PH_RT8 ||
                phase_reg == uart_rx_pkg::PH_RT9) begin
              ones_cnt_reg <= ones_now;
            end
            // start stays 0; any 1 is noise
            if (phase_reg == uart_rx_pkg::PH_RT10) begin
              ones_cnt_reg <= 2'b00;
              if (ones_now != 2'b00) begin
                frame_noise_reg <= 1'b1;
              end
            end
            if (phase_reg == uart_rx_pkg::PH_RT16) begin
              state_reg <= uart_rx_pkg::S_BITS;
              bit_idx_reg <= 4'h0;
            end
          end
          uart_rx_pkg::S_BITS: begin
            if (phase_reg == uart_rx_pkg::PH_RT8 ||
                phase_reg == uart_rx_pkg::PH_RT9) begin
              ones_cnt_reg <= ones_now;
            end
            if (phase_reg == uart_rx_pkg::PH_RT10) begin
              ones_cnt_reg <= 2'b00;
              if (^ones_now) begin
                frame_noise_reg <= 1'b1;
              end
              if (bit_idx_reg == stop_idx) begin
                state_reg <= uart_rx_pkg::S_SEARCH;
                done_reg <= 1'b1;
                stop_bit_reg <= ones_now[1];
                // refill history after a framing error
                if (!ones_now[1] && !is_break) begin
                  hist_reg <= 3'b111;
                end
              end else begin
                shift_reg[bit_idx_reg] <= ones_now[1];
              end
            end
            if (phase_reg == uart_rx_pkg::PH_RT16) begin
              bit_idx_reg <= bit_idx_reg + 4'h1;
            end
          end
          default: begin
            state_reg <= uart_rx_pkg::S_SEARCH;
          end
        endcase
      end
    end
  end

  // Idle line timing
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_cnt_reg <= 8'h00;
      idle_hit_reg <= 1'b0;
    end else begin
      idle_hit_reg <= 1'b0;
      if (!receiver_enable_reg || (tick_reg && !rx_level)) begin
        idle_cnt_reg <= 8'h00;
      // where counting starts
      // Saturate at the limit so a format change cannot wrap the count
      end else if (tick_reg && idle_cnt_reg < idle_thr &&
                   (!ctrl_one_reg[uart_rx_pkg::C1_QUIET_START] ||
                    state_reg == uart_rx_pkg::S_SEARCH)) begin
        idle_cnt_reg <= idle_cnt_reg + 8'h01;
        idle_hit_reg <= idle_cnt_reg + 8'h01 == idle_thr;
      end
    end
  end

  // Receive buffer and flags; a set in the clearing cycle wins
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_reg <= 8'h00;
      ninth_rx_bit_reg <= 1'b0;
      rx_full_flag_reg <= 1'b0;
      overrun_flag_reg <= 1'b0;
      noise_flag_reg <= 1'b0;
      framing_error_flag_reg <= 1'b0;
      quiet_line_flag_reg <= 1'b0;
      quiet_armed_reg <= 1'b0;
      status_seen_reg <= 1'b0;
    end else begin
      if (reg_rd && reg_addr == uart_rx_pkg::STATUS_ONE_OFS &&
          (rx_full_flag_reg || quiet_line_flag_reg)) begin
        status_seen_reg <= 1'b1;
      end
      if (clear_now) begin
        status_seen_reg <= 1'b0;
        rx_full_flag_reg <= 1'b0;
        overrun_flag_reg <= 1'b0;
        noise_flag_reg <= 1'b0;
        framing_error_flag_reg <= 1'b0;
        quiet_line_flag_reg <= 1'b0;
      end
      if (done_reg && (!rx_sleep_reg || wake_addr) &&
          !framing_error_flag_reg) begin
        if (rx_full_flag_reg && !clear_now) begin
          overrun_flag_reg <= 1'b1;
        end else begin
          data_reg <= nine_bit ? shift_reg[7:0] : shift_reg[7:0];
          ninth_rx_bit_reg <= nine_bit & shift_reg[8];
          rx_full_flag_reg <= 1'b1;
          quiet_armed_reg <= 1'b1;
          noise_flag_reg <= frame_noise_reg;
          framing_error_flag_reg <= !stop_bit_reg;
        end
      end
      // quiet flag only when sleep allows it
      if (idle_hit_reg && quiet_armed_reg &&
          (!rx_sleep_reg || ctrl_one_reg[uart_rx_pkg::C1_IDLE_SLEEP])) begin
        quiet_line_flag_reg <= 1'b1;
        quiet_armed_reg <= 1'b0;
      end
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[uart_rx_pkg::S1_FRAMING] = framing_error_flag_reg;
    status_byte[uart_rx_pkg::S1_NOISE] = noise_flag_reg;
    status_byte[uart_rx_pkg::S1_OVERRUN] = overrun_flag_reg;
    status_byte[uart_rx_pkg::S1_QUIET] = quiet_line_flag_reg;
    status_byte[uart_rx_pkg::S1_FULL] = rx_full_flag_reg;
  end

  // Read data stands one cycle, zero otherwise
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        uart_rx_pkg::CTRL_ONE_OFS: reg_rdata <= ctrl_one_reg;
        uart_rx_pkg::CTRL_TWO_OFS: reg_rdata <= {6'h00, rx_sleep_reg,
                                                 receiver_enable_reg};
        uart_rx_pkg::STATUS_ONE_OFS: reg_rdata <= status_byte;
        uart_rx_pkg::CTRL_THREE_OFS: reg_rdata <= {7'h00, ninth_rx_bit_reg};
        uart_rx_pkg::DATA_PORT_OFS: reg_rdata <= data_reg;
        uart_rx_pkg::BAUD_DIV_OFS: reg_rdata <= baud_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  full_set_a: assert property (done_reg && !rx_sleep_reg &&
    !framing_error_flag_reg && !rx_full_flag_reg |=> rx_full_flag_reg)
    else $error("character not stored");
  overrun_keep_a: assert property (done_reg && !rx_sleep_reg &&
    !framing_error_flag_reg && rx_full_flag_reg && !clear_now
    |=> overrun_flag_reg && $stable(data_reg))
    else $error("overrun handling wrong");
  edge_resync_a: assert property (edge_det |=> phase_reg == 4'h0)
    else $error("phase not resynchronised");
  start_reject_a: assert property (tick_reg &&
    state_reg == uart_rx_pkg::S_START &&
    phase_reg == uart_rx_pkg::PH_RT7 && zeros_now < 2'b10
    |=> state_reg == uart_rx_pkg::S_SEARCH)
    else $error("noise taken as start");
  sleep_quiet_a: assert property (done_reg && rx_sleep_reg &&
    !wake_addr |=> !$rose(rx_full_flag_reg))
    else $error("flag set while asleep");
  fe_block_a: assert property (done_reg &&
    framing_error_flag_reg |=> $stable(data_reg))
    else $error("transfer despite framing error");
  preload_a: assert property (tick_reg &&
    state_reg == uart_rx_pkg::S_BITS
    && phase_reg == uart_rx_pkg::PH_RT10 && bit_idx_reg == stop_idx
    && !ones_now[1] && !is_break |=> hist_reg == 3'b111)
    else $error("edge history not refilled");
  idle_wake_a: assert property (idle_hit_reg && rx_sleep_reg &&
    !ctrl_one_reg[uart_rx_pkg::C1_EXIT_METHOD] |=> !rx_sleep_reg)
    else $error("idle did not wake");
  addr_wake_a: assert property (wake_addr && !rx_full_flag_reg &&
    !framing_error_flag_reg |=> !rx_sleep_reg && rx_full_flag_reg)
    else $error("address mark not taken");
  full_clear_a: assert property ($fell(rx_full_flag_reg)
    |-> $past(clear_now))
    else $error("full cleared without sequence");

  store_c: cover property (done_reg ##1 $rose(rx_full_flag_reg));
  overrun_c: cover property ($rose(overrun_flag_reg));
  idle_wake_c: cover property (idle_hit_reg && rx_sleep_reg);
  addr_wake_c: cover property (wake_addr);
endmodule

//--- verif/serial_sender.sv
// Remote serial transmitter model that drives the receive line
module serial_sender #(
  parameter int BIT_CYCLES = 64
) (
  // Clock
  input wire logic core_clk,
  // Serial line
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic inv;
  initial begin
    inv = 1'b0;
    line = 1'b1;
  end
  // Caller keeps the receiver disabled, or the flip looks like a start
  task automatic set_inv(input logic v);
    @(posedge core_clk);
    inv = v;
    line <= ~v;
  endtask
  // One bit time; a glitch flips one sample tick's worth of cycles
  task automatic put_bit(input logic lvl, input int glitch_at);
    for (int c = 0; c < BIT_CYCLES; c++) begin
      @(posedge core_clk);
      if (c >= glitch_at && c < glitch_at + BIT_CYCLES / 16) begin
        line <= ~lvl ^ inv;
      end else begin
        line <= lvl ^ inv;
      end
    end
  endtask
  // start 0, data LSB first, then the stop level
  task automatic send(input logic [8:0] data, input int nbits,
                      input logic stop, input int glitch_at);
    put_bit(1'b0, -BIT_CYCLES);
    for (int i = 0; i < nbits; i++) begin
      put_bit(data[i], (i == 0) ? glitch_at : -BIT_CYCLES);
    end
    put_bit(stop, -BIT_CYCLES);
  endtask
endmodule

//--- verif/tb.sv
// Self-checking bench for the serial receiver with wakeup
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 3;
  // Small divisor keeps frames short: sixteen ticks of DIV+1 cycles
  localparam int BIT = (DIV + 1) * 16;
  localparam int NONE = -BIT;
  localparam logic [2:0] C1 = uart_rx_pkg::CTRL_ONE_OFS;
  localparam logic [2:0] C2 = uart_rx_pkg::CTRL_TWO_OFS;
  localparam logic [2:0] ST = uart_rx_pkg::STATUS_ONE_OFS;
  localparam logic [2:0] C3 = uart_rx_pkg::CTRL_THREE_OFS;
  localparam logic [2:0] DP = uart_rx_pkg::DATA_PORT_OFS;
  localparam logic [2:0] BD = uart_rx_pkg::BAUD_DIV_OFS;
  localparam logic [7:0] EN = 8'(1 << uart_rx_pkg::C2_ENABLE);
  localparam logic [7:0] SLP = 8'(1 << uart_rx_pkg::C2_SLEEP);
  localparam logic [7:0] NINE = 8'(1 << uart_rx_pkg::C1_NINE_BIT);
  localparam logic [7:0] MARK = 8'(1 << uart_rx_pkg::C1_EXIT_METHOD);
  localparam logic [7:0] LATE = 8'(1 << uart_rx_pkg::C1_QUIET_START);
  localparam logic [7:0] INV = 8'(1 << uart_rx_pkg::C1_INVERT);
  localparam logic [7:0] IDS = 8'(1 << uart_rx_pkg::C1_IDLE_SLEEP);
  localparam logic [7:0] FULL = 8'(1 << uart_rx_pkg::S1_FULL);
  localparam logic [7:0] QUIET = 8'(1 << uart_rx_pkg::S1_QUIET);
  localparam logic [7:0] OVR = 8'(1 << uart_rx_pkg::S1_OVERRUN);
  localparam logic [7:0] NOISE = 8'(1 << uart_rx_pkg::S1_NOISE);
  localparam logic [7:0] FRM = 8'(1 << uart_rx_pkg::S1_FRAMING);
  logic core_clk;
  logic reset_n;
  logic serial_input;
  logic reg_wr;
  logic reg_rd;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic [7:0] rd_val;
  int mismatches = 0;
  int check_count = 0;

  uart_receiver_wakeup i_dut (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .serial_input(serial_input),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );
  serial_sender #(.BIT_CYCLES(BIT)) i_sender (
    .core_clk(core_clk),
    .line(serial_input)
  );

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // The edge history needs three idle ones before a start can be seen
  task automatic enable_rx();
    wr(C2, EN);
    repeat (BIT) @(posedge core_clk);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask
  task automatic check8(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic expect_reg(input string what, input logic [2:0] a,
                            input logic [7:0] exp);
    rd(a);
    check8(what, exp, rd_val);
  endtask
  // status read first, then the data read clears the flags
  task automatic take(input logic [7:0] status, input logic [7:0] data);
    expect_reg("status", ST, status);
    expect_reg("data", DP, data);
  endtask
  task automatic wait_full();
    rd(ST);
    for (int n = 0; n < 10 * BIT && (rd_val & FULL) == 8'h00; n++) begin
      rd(ST);
    end
  endtask
  task automatic mark_wake(input logic [7:0] c1, input logic [8:0] stay,
                           input logic [8:0] go);
    wr(C1, c1 | MARK);
    wr(C2, EN | SLP);
    i_sender.send(stay, c1[0] ? 9 : 8, 1'b1, BIT / 2 + 2);
    expect_reg("status", ST, 8'h00);
    expect_reg("sleep", C2, EN | SLP);
    i_sender.send(go, c1[0] ? 9 : 8, 1'b1, NONE);
    expect_reg("sleep", C2, EN);
    take(FULL, go[7:0]);
  endtask
  // Sleep is set one bit into an all-ones frame so the count starts clean
  task automatic idle_wake(input logic [7:0] c1, input int asleep_bits,
                           input int awake_bits, input logic [7:0] status);
    wr(C1, c1);
    fork
      i_sender.send(9'h1ff, c1[0] ? 9 : 8, 1'b1, NONE);
      begin
        repeat (BIT) @(posedge core_clk);
        wr(C2, EN | SLP);
      end
    join
    repeat (asleep_bits * BIT) @(posedge core_clk);
    expect_reg("asleep", C2, EN | SLP);
    repeat ((awake_bits - asleep_bits) * BIT) @(posedge core_clk);
    expect_reg("awake", C2, EN);
    expect_reg("quiet", ST, status);
  endtask
  task automatic close_out();
    if (mismatches == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    close_out();
  end

  initial begin
    reset_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    expect_reg("ctrl_one", C1, uart_rx_pkg::CTRL_ONE_RST);
    expect_reg("ctrl_two", C2, uart_rx_pkg::CTRL_TWO_RST);
    expect_reg("baud", BD, uart_rx_pkg::BAUD_DIV_RST);
    wr(3'h6, 8'hff);
    expect_reg("unmapped", 3'h6, 8'h00);
    wr(ST, 8'hff);
    expect_reg("status", ST, 8'h00);
    wr(BD, 8'(DIV));
    enable_rx();
    i_sender.send(9'h0a5, 8, 1'b1, NONE);
    expect_reg("data", DP, 8'ha5);
    expect_reg("status", ST, FULL);
    take(FULL, 8'ha5);
    expect_reg("status", ST, 8'h00);
    i_sender.send(9'h03c, 8, 1'b1, NONE);
    i_sender.send(9'h0c2, 8, 1'b1, BIT / 2 + 2);
    take(FULL | OVR, 8'h3c);
    i_sender.send(9'h0f0, 8, 1'b1, BIT / 2 + 2);
    take(FULL | NOISE, 8'hf0);
    // Back-to-back frames after a zero stop need the refilled history
    fork
      begin
        i_sender.send(9'h033, 8, 1'b0, NONE);
        i_sender.send(9'h05a, 8, 1'b1, NONE);
      end
      begin
        wait_full();
        take(FULL | FRM, 8'h33);
      end
    join
    take(FULL, 8'h5a);
    // With the framing flag left set the next character is dropped
    i_sender.send(9'h033, 8, 1'b0, NONE);
    i_sender.send(9'h05a, 8, 1'b1, NONE);
    take(FULL | FRM, 8'h33);
    expect_reg("status", ST, 8'h00);
    // A one-sample low pulse must not be taken as a start
    i_sender.put_bit(1'b1, 0);
    i_sender.send(9'h0a5, 8, 1'b1, NONE);
    take(FULL, 8'ha5);
    wr(C2, 8'h00);
    i_sender.send(9'h055, 8, 1'b1, NONE);
    expect_reg("status", ST, 8'h00);
    i_sender.set_inv(1'b1);
    wr(C1, INV);
    enable_rx();
    i_sender.send(9'h096, 8, 1'b1, NONE);
    take(FULL, 8'h96);
    wr(C2, 8'h00);
    i_sender.set_inv(1'b0);
    wr(C1, NINE);
    enable_rx();
    i_sender.send(9'h1c3, 9, 1'b1, NONE);
    take(FULL, 8'hc3);
    expect_reg("ninth", C3, 8'h01);
    mark_wake(8'h00, 9'h010, 9'h092);
    mark_wake(NINE, 9'h0fe, 9'h155);
    idle_wake(8'h00, 0, 2, 8'h00);
    idle_wake(NINE | LATE, 9, 12, 8'h00);
    idle_wake(LATE | IDS, 8, 11, QUIET);
    rd(DP);
    expect_reg("status", ST, 8'h00);
    close_out();
  end
endmodule
